/* File: design/lfpa_phase_accum.sv */
`timescale 1ns/100ps
`default_nettype none
module lfpa_phase_accum
  import lfpa_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // tuning
  input  wire logic [47:0] step,
  input  wire logic [15:0] offset,
  input  wire logic        offset_en,
  // sinusoid phase
  output logic      [15:0] phase
);

  logic [47:0] acc;
  wire  [15:0] applied = offset_en ? offset : 16'h0000;

  // modulo 2^48 running total, rolls over keeping the excess
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      acc   <= 48'h0;
      phase <= 16'h0000;
    end
    else
    begin
      acc   <= acc + step;
      phase <= acc[47:32] + applied;
    end
  end

  a_accum_step: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> acc == 48'($past(acc) + $past(step)))
    else $error("accumulator did not add step");

  a_offset_applied: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> phase == 16'($past(acc[47:32]) + $past(applied)))
    else $error("phase offset not applied");

endmodule
`default_nettype wire

/* File: design/lfpa_pkg.sv */
package lfpa_pkg;

  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_DECIM   = 8'h04;
  localparam logic [7:0] ADDR_COEF    = 8'h08;
  localparam logic [7:0] ADDR_TONE_LO = 8'h0C;
  localparam logic [7:0] ADDR_TONE_HI = 8'h10;
  localparam logic [7:0] ADDR_PHASE   = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_TUNE_LO = 8'h1C;
  localparam logic [7:0] ADDR_TUNE_HI = 8'h20;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CTRL_CLOSE    = 0;
  localparam int CTRL_TONE_EST = 1;
  localparam int CTRL_HOLD_AUTO = 2;
  localparam int CTRL_HOLD_MAN = 3;
  localparam int CTRL_EST_EN   = 4;
  localparam int COEF_KI_LSB   = 8;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [4:0]  DECIM_RESET = 5'h05;
  localparam logic [12:0] COEF_RESET  = 13'h0400;
  localparam logic [4:0]  EXP_MIN     = 5'h05;
  localparam logic [4:0]  EXP_MAX     = 5'h10;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {mode_tone, mode_hold, mode_loop, mode_estimate} lfpa_mode_type;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } lfpa_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } lfpa_axi_rsp_type;

  typedef struct packed {
    logic        valid;
    logic [23:0] err;
  } lfpa_error_type;

  typedef struct packed {
    logic        valid;
    logic [47:0] word;
    logic [15:0] phase;
  } lfpa_estimate_type;

endpackage

/* File: design/lfpa_rate_comb.sv */
`timescale 1ns/100ps
`default_nettype none
module lfpa_rate_comb
  import lfpa_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // decimated side
  input  wire logic        load,
  input  wire logic [47:0] sample,
  input  wire logic [4:0]  exp_sel,
  input  wire logic        preload,
  // full rate side
  output logic      [47:0] out
);

  logic [47:0] held;
  logic [47:0] held_prev;
  logic [63:0] sum;
  wire  [63:0] next_sum = sum + {16'h0000, held} - {16'h0000, held_prev};
  wire  [63:0] pre_sum  = {16'h0000, sample} << exp_sel;
  wire  [63:0] scaled   = next_sum >> exp_sel;

  // zero-order hold then running sum over one ratio: squared comb, unity dc
  always_ff @(posedge ref_clk)
  begin
    if (reset || preload)
    begin
      held      <= reset ? 48'h0 : sample;
      held_prev <= reset ? 48'h0 : sample;
      sum       <= reset ? 64'h0 : pre_sum;
      out       <= reset ? 48'h0 : sample;
    end
    else
    begin
      if (load)
      begin
        held      <= sample;
        held_prev <= held;
      end
      sum <= next_sum;
      out <= scaled[47:0];
    end
  end

  a_comb_hold_stable: assert property (@(posedge ref_clk) disable iff (reset)
    !load && !preload |=> held == $past(held))
    else $error("comb hold changed without load");

endmodule
`default_nettype wire

/* File: design/lfpa_top.sv */
// Summary of operation
// - loop filter integrates and low-pass filters phase errors, proportional plus integral
// - error samples arrive once per prescaled reference edge, summed until next tick
// - filter runs at sample clock divided by the decimation ratio
// - ratio is two to a 5-bit exponent, clamped to 5..16
// - comb stage translates filter output to the full sample rate
// - comb is squared boxcar over the ratio with unity dc gain
// - comb nulls fall at multiples of sample clock over ratio
// - accumulator adds the 48-bit tuning step word every cycle
// - accumulator wraps modulo two to the 48, no saturation
// - output frequency equals step word over 2^48 times sample clock
// - 16-bit phase offset word is added to the sinusoid phase in single tone and holdover only
// - one loop closure bit selects open or closed loop
// - single tone uses stored tone word and ignores reference inputs
// - single tone may take word and phase from the estimator
// - holdover replays retained words, allowed only after loop closed once
// - holdover entry and exit automatic or manual by control bits
// - closed loop takes step word continuously from the filter
// - closed loop ignores the programmed phase offset
// - loop idle while estimating, tracking starts after estimate hand-over
`timescale 1ns/100ps
`default_nettype none
module lfpa_top
  import lfpa_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // register bus
  input  wire lfpa_axi_req_type  axi_req,
  output lfpa_axi_rsp_type       axi_rsp,
  // phase detector and estimator
  input  wire lfpa_error_type    phase_error,
  input  wire lfpa_estimate_type estimate,
  input  wire logic              ref_lost,
  // synthesizer outputs
  output logic      [47:0]       tuning_step_word,
  output logic      [15:0]       sine_phase
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = data[8*i +: 8];
    end
    return res;
  endfunction

  function automatic logic [4:0] clamp_exp(input logic [4:0] e);
    return (e < EXP_MIN) ? EXP_MIN : ((e > EXP_MAX) ? EXP_MAX : e);
  endfunction

  function automatic logic [47:0] sext48(input logic [31:0] v);
    return {{16{v[31]}}, v};
  endfunction

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0]    ctrl;
  logic [4:0]    decim_exp;
  logic [12:0]   coef;
  logic [31:0]   tone_lo;
  logic [15:0]   tone_hi;
  logic [15:0]   phase_off;
  logic          aw_held;
  logic [7:0]    aw_addr;
  logic          w_held;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          bvalid;
  logic [1:0]    bresp;
  logic          rvalid;
  logic [31:0]   rdata;
  logic [1:0]    rresp;

  // ----------------------------------------
  // loop state
  // ----------------------------------------
  lfpa_mode_type mode;
  lfpa_mode_type next_mode;
  logic          ever_locked;
  logic          est_done;
  logic [47:0]   est_word;
  logic [15:0]   est_phase;
  logic [15:0]   decim_count;
  logic [31:0]   err_sum;
  logic [47:0]   integ;
  logic [47:0]   filt_out;
  logic [47:0]   held_word;
  logic [47:0]   comb_out;
  logic [47:0]   next_step;
  logic [15:0]   next_offset;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire        aw_take   = axi_req.awvalid && !aw_held && !bvalid;
  wire        w_take    = axi_req.wvalid && !w_held && !bvalid;
  wire        do_write  = aw_held && w_held && !bvalid;
  wire        ar_take   = axi_req.arvalid && !rvalid;
  wire [31:0] wr_ctrl   = merge({24'h0, ctrl}, w_data, w_strb);
  wire [31:0] wr_decim  = merge({27'h0, decim_exp}, w_data, w_strb);
  wire [31:0] wr_coef   = merge({19'h0, coef}, w_data, w_strb);
  wire [31:0] wr_tlo    = merge(tone_lo, w_data, w_strb);
  wire [31:0] wr_thi    = merge({16'h0, tone_hi}, w_data, w_strb);
  wire [31:0] wr_phase  = merge({16'h0, phase_off}, w_data, w_strb);
  wire        wr_mapped = (aw_addr == ADDR_CTRL) || (aw_addr == ADDR_DECIM)
                       || (aw_addr == ADDR_COEF) || (aw_addr == ADDR_TONE_LO)
                       || (aw_addr == ADDR_TONE_HI) || (aw_addr == ADDR_PHASE);
  wire [31:0] status    = {27'h0, est_done, ever_locked, 1'b0, mode};
  wire        rd_mapped = (axi_req.araddr <= ADDR_TUNE_HI) && (axi_req.araddr[1:0] == 2'h0);

  // read data selection
  logic [31:0] rd_mux;
  always_comb
  begin
    case (axi_req.araddr)
      ADDR_CTRL:    rd_mux = {24'h0, ctrl};
      ADDR_DECIM:   rd_mux = {27'h0, decim_exp};
      ADDR_COEF:    rd_mux = {19'h0, coef};
      ADDR_TONE_LO: rd_mux = tone_lo;
      ADDR_TONE_HI: rd_mux = {16'h0, tone_hi};
      ADDR_PHASE:   rd_mux = {16'h0, phase_off};
      ADDR_STATUS:  rd_mux = status;
      ADDR_TUNE_LO: rd_mux = tuning_step_word[31:0];
      ADDR_TUNE_HI: rd_mux = {16'h0, tuning_step_word[47:32]};
      default:      rd_mux = 32'h0;
    endcase
  end

  assign axi_rsp.awready = !aw_held && !bvalid;
  assign axi_rsp.wready  = !w_held && !bvalid;
  assign axi_rsp.bvalid  = bvalid;
  assign axi_rsp.bresp   = bresp;
  assign axi_rsp.arready = !rvalid;
  assign axi_rsp.rvalid  = rvalid;
  assign axi_rsp.rdata   = rdata;
  assign axi_rsp.rresp   = rresp;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  // write address and data are held separately, response after both
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= axi_req.awaddr;
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= axi_req.wdata;
        w_strb <= axi_req.wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && axi_req.bready)
        bvalid <= 1'b0;
    end
  end

  // register writes from software
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ctrl      <= CTRL_RESET;
      decim_exp <= DECIM_RESET;
      coef      <= COEF_RESET;
      tone_lo   <= 32'h0;
      tone_hi   <= 16'h0000;
      phase_off <= 16'h0000;
    end
    else if (do_write)
    begin
      case (aw_addr)
        ADDR_CTRL:    ctrl      <= wr_ctrl[7:0];
        ADDR_DECIM:   decim_exp <= wr_decim[4:0];
        ADDR_COEF:    coef      <= wr_coef[12:0];
        ADDR_TONE_LO: tone_lo   <= wr_tlo;
        ADDR_TONE_HI: tone_hi   <= wr_thi[15:0];
        ADDR_PHASE:   phase_off <= wr_phase[15:0];
        default:      ctrl      <= ctrl;
      endcase
    end
  end

  // read channel, one cycle answer
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && axi_req.rready)
      rvalid <= 1'b0;
  end

  // ----------------------------------------
  // decimation and loop filter
  // ----------------------------------------
  wire [4:0]         eff_exp   = clamp_exp(decim_exp);
  wire [16:0]        ratio     = 17'h00001 << eff_exp;
  wire [16:0]        last_full = ratio - 17'h00001;
  wire               tick      = decim_count == last_full[15:0];
  wire [31:0]        err_in    = {{8{phase_error.err[23]}}, phase_error.err};
  wire signed [47:0] err48     = sext48(err_sum);
  wire signed [47:0] int_term  = err48 <<< coef[COEF_KI_LSB +: 5];
  wire signed [47:0] prop_term = err48 <<< coef[4:0];
  wire [47:0]        next_int  = integ + int_term;
  wire               loop_tick = tick && (mode == mode_loop);

  // decimation counter
  always_ff @(posedge ref_clk)
  begin
    if (reset || tick)
      decim_count <= 16'h0000;
    else
      decim_count <= decim_count + 16'h0001;
  end

  // error samples summed between ticks; a sample on the tick starts the next sum
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      err_sum <= 32'h0;
    else if (tick)
      err_sum <= phase_error.valid ? err_in : 32'h0;
    else if (phase_error.valid)
      err_sum <= err_sum + err_in;
  end

  // proportional plus integral path; while open, integrator tracks the word about to be
  // issued, so an estimate handed over in the next-to-last open cycle reaches the comb preload
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      integ     <= 48'h0;
      filt_out  <= 48'h0;
      held_word <= 48'h0;
    end
    else if (mode != mode_loop)
    begin
      integ    <= next_step;
      filt_out <= next_step;
    end
    else if (loop_tick)
    begin
      integ     <= next_int;
      filt_out  <= next_int + prop_term;
      held_word <= filt_out;
    end
  end

  lfpa_rate_comb u_comb (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (tick),
    .sample  (filt_out),
    .exp_sel (eff_exp),
    .preload (mode != mode_loop),
    .out     (comb_out)
  );

  // ----------------------------------------
  // mode control
  // ----------------------------------------
  wire hold_req = ctrl[CTRL_HOLD_MAN] || (ctrl[CTRL_HOLD_AUTO] && ref_lost);

  // mode selection
  always_comb
  begin
    if (!ctrl[CTRL_CLOSE])
      next_mode = (ctrl[CTRL_HOLD_MAN] && ever_locked) ? mode_hold : mode_tone;
    else if (ctrl[CTRL_EST_EN] && !est_done)
      next_mode = mode_estimate;
    else if (hold_req && ever_locked)
      next_mode = mode_hold;
    else
      next_mode = mode_loop;
  end

  // step word and offset source per mode
  always_comb
  begin
    case (mode)
      mode_tone:
      begin
        next_step   = ctrl[CTRL_TONE_EST] ? est_word : {tone_hi, tone_lo};
        next_offset = ctrl[CTRL_TONE_EST] ? est_phase : phase_off;
      end
      mode_hold:
      begin
        next_step   = held_word;
        next_offset = phase_off;
      end
      mode_loop:
      begin
        next_step   = comb_out;
        next_offset = 16'h0000;
      end
      mode_estimate:
      begin
        next_step   = estimate.valid ? estimate.word : tuning_step_word;
        next_offset = 16'h0000;
      end
      default:
      begin
        next_step   = tuning_step_word;
        next_offset = 16'h0000;
      end
    endcase
  end

  // mode, lock history and estimator hand-over
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      mode             <= mode_tone;
      ever_locked      <= 1'b0;
      est_done         <= 1'b0;
      est_word         <= 48'h0;
      est_phase        <= 16'h0000;
      tuning_step_word <= 48'h0;
    end
    else
    begin
      mode             <= next_mode;
      tuning_step_word <= next_step;
      if (loop_tick)
        ever_locked <= 1'b1;
      if (estimate.valid)
      begin
        est_word  <= estimate.word;
        est_phase <= estimate.phase;
      end
      if (estimate.valid && mode == mode_estimate)
        est_done <= 1'b1;
      else if (!ctrl[CTRL_CLOSE] || !ctrl[CTRL_EST_EN])
        est_done <= 1'b0;
    end
  end

  lfpa_phase_accum u_accum (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .step      (tuning_step_word),
    .offset    (next_offset),
    .offset_en (mode == mode_tone || mode == mode_hold),
    .phase     (sine_phase)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_exp_in_range: assert property (@(posedge ref_clk) disable iff (reset)
    tick |-> decim_count >= 16'h001F && eff_exp >= EXP_MIN && eff_exp <= EXP_MAX)
    else $error("decimation exponent out of range");

  a_tick_spacing: assert property (@(posedge ref_clk) disable iff (reset)
    tick |=> !tick [*8])
    else $error("decimation ticks too close");

  a_hold_needs_lock: assert property (@(posedge ref_clk) disable iff (reset)
    mode == mode_hold |-> ever_locked)
    else $error("holdover without prior lock");

  a_tone_word_used: assert property (@(posedge ref_clk) disable iff (reset)
    mode == mode_tone && !ctrl[CTRL_TONE_EST] |=> tuning_step_word == $past({tone_hi, tone_lo}))
    else $error("single tone word not used");

  a_estimate_idle: assert property (@(posedge ref_clk) disable iff (reset)
    mode == mode_estimate && !estimate.valid |=> $stable(tuning_step_word))
    else $error("step word moved while estimating");

  a_loop_follows_comb: assert property (@(posedge ref_clk) disable iff (reset)
    mode == mode_loop |=> tuning_step_word == $past(comb_out))
    else $error("closed loop not fed by comb");

  a_open_loop_bit: assert property (@(posedge ref_clk) disable iff (reset)
    !ctrl[CTRL_CLOSE] |=> mode == mode_tone || mode == mode_hold)
    else $error("loop active with closure bit clear");

  a_write_response: assert property (@(posedge ref_clk) disable iff (reset)
    do_write |=> bvalid && bresp == (($past(wr_mapped)) ? RESP_OKAY : RESP_SLVERR))
    else $error("write response wrong");

endmodule
`default_nettype wire

/* File: dv/lfpa_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lfpa_far_model
  import lfpa_pkg::*;
#(
  parameter int PERIOD = 8
)
(
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            reset,
  // stimulus control
  input  wire logic            run,
  input  wire logic [23:0]     err_val,
  input  wire logic            est_go,
  input  wire logic [47:0]     est_word,
  // detector and estimator side
  output var lfpa_error_type    phase_error,
  output var lfpa_estimate_type estimate
);
  int                cnt = 0;
  lfpa_error_type    pe  = '0;
  lfpa_estimate_type es  = '0;

  // one sample per prescaled reference edge, payload scrambled between
  always @(posedge ref_clk)
  begin
    cnt      <= (reset || cnt == PERIOD - 1) ? 0 : cnt + 1;
    pe.valid <= run && cnt == 0;
    pe.err   <= (run && cnt == 0) ? err_val : ~pe.err;
    es.valid <= est_go;
    es.word  <= est_go ? est_word : ~es.word;
    es.phase <= est_go ? 16'h0055 : ~es.phase;
  end

  // drive the design inputs
  assign phase_error = pe;
  assign estimate    = es;
endmodule
`default_nettype wire

/* File: dv/lfpa_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module lfpa_top_tb
  import lfpa_pkg::*;
;
  // ----
  // bench signals
  // ----
  typedef struct {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [1:0]  b;
    logic [31:0] q;
    logic [1:0]  r;
  } lfpa_row_type;
  localparam logic [1:0]  OK   = RESP_OKAY;
  localparam logic [1:0]  SE   = RESP_SLVERR;
  localparam logic [47:0] EST  = 48'h0123_4567_89AB;
  localparam logic [47:0] TONE = 48'h4000_0000_0000;
  logic              ref_clk  = 1'b0;
  logic              reset    = 1'b1;
  logic              ref_lost = 1'b0;
  logic              run      = 1'b0;
  logic              est_go   = 1'b0;
  logic [23:0]       err_val  = 24'h000000;
  lfpa_axi_req_type  axi_req  = '0;
  lfpa_axi_rsp_type  axi_rsp;
  lfpa_error_type    phase_error;
  lfpa_estimate_type estimate;
  logic [47:0]       tuning_step_word;
  logic [47:0]       h;
  logic [15:0]       sine_phase;
  logic [15:0]       p0;
  logic [31:0]       rd;
  logic [1:0]        rs;
  int                err_count = 0;
  int                cmp_count = 0;
  lfpa_row_type      rows [13];

  // clock
  always #2 ref_clk = ~ref_clk;

  lfpa_top dut (.ref_clk(ref_clk), .reset(reset), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .phase_error(phase_error), .estimate(estimate), .ref_lost(ref_lost),
    .tuning_step_word(tuning_step_word), .sine_phase(sine_phase));

  lfpa_far_model #(.PERIOD(8)) far (.ref_clk(ref_clk), .reset(reset), .run(run),
    .err_val(err_val), .est_go(est_go), .est_word(EST), .phase_error(phase_error),
    .estimate(estimate));

  // verdict and comparison helpers
  task automatic give_verdict();
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // axi4-lite write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    axi_req.awaddr  <= a;
    axi_req.awvalid <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hF;
    axi_req.wvalid  <= 1'b1;
    axi_req.bready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge ref_clk);
      if (axi_req.awvalid && axi_rsp.awready)
        axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready)
        axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid === 1'b1)
        break;
    end
    r = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
    if (n == 50)
      err_count++;
    if (n == 50)
      give_verdict();
  endtask

  // axi4-lite read
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    axi_req.araddr  <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge ref_clk);
      if (axi_req.arvalid && axi_rsp.arready)
        axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid === 1'b1)
        break;
    end
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
    if (n == 50)
      err_count++;
    if (n == 50)
      give_verdict();
  endtask

  // control write, then let the mode settle
  task automatic ctl(input logic [31:0] d);
    wr(ADDR_CTRL, d, rs);
    chk("ctrl bresp", OK, rs);
    cyc(4);
  endtask

  // mode, lock and estimate flags
  task automatic st(input logic [31:0] e);
    rdr(ADDR_STATUS, rd, rs);
    chk("status", e, rd & 32'h1B);
  endtask

  // main sequence
  initial
  begin
    rows = '{
      '{ADDR_CTRL,    1'b0, 32'h0,         OK, 32'h0,    OK},
      '{ADDR_DECIM,   1'b0, 32'h0,         OK, 32'h5,    OK},
      '{ADDR_COEF,    1'b0, 32'h0,         OK, 32'h400,  OK},
      '{ADDR_STATUS,  1'b0, 32'h0,         OK, 32'h0,    OK},
      '{ADDR_TUNE_HI, 1'b0, 32'h0,         OK, 32'h0,    OK},
      '{ADDR_DECIM,   1'b1, 32'hFFFF_FFFF, OK, 32'h1F,   OK},
      '{ADDR_DECIM,   1'b1, 32'h5,         OK, 32'h5,    OK},
      '{ADDR_TONE_LO, 1'b1, 32'h0,         OK, 32'h0,    OK},
      '{ADDR_TONE_HI, 1'b1, 32'hFFFF_4000, OK, 32'h4000, OK},
      '{ADDR_PHASE,   1'b1, 32'h1_2345,    OK, 32'h2345, OK},
      '{ADDR_STATUS,  1'b1, 32'h1,         SE, 32'h0,    OK},
      '{8'h24,        1'b1, 32'h1,         SE, 32'h0,    SE},
      '{8'h02,        1'b0, 32'h0,         OK, 32'h0,    SE}};
    cyc(2);
    reset <= 1'b0;
    run   <= 1'b1;
    chk("reset step", 48'h0, tuning_step_word);
    chk("reset phase", 48'h0, sine_phase);
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d, rs);
      if (rows[i].w)
        chk("bresp", rows[i].b, rs);
      rdr(rows[i].a, rd, rs);
      chk("rdata", rows[i].q, rd);
      chk("rresp", rows[i].r, rs);
    end
    // tone mode held from reset with the software tone word, large error must not matter
    err_val <= 24'h7FFFFF;
    cyc(40);
    chk("tone", TONE, tuning_step_word);
    p0 = sine_phase;
    cyc(1);
    chk("advance", 48'h4000, 16'(sine_phase - p0));
    cyc(3);
    chk("wrap", p0, sine_phase);
    wr(ADDR_PHASE, 32'h2468, rs);
    cyc(4);
    chk("offset", 48'h0123, 14'(sine_phase - p0));
    err_val <= 24'h000000;
    cyc(40);
    // holdover refused before first lock
    ctl(32'h08);
    st(32'h00);
    // closed loop, zero error keeps the word
    ctl(32'h01);
    cyc(200);
    st(32'h0A);
    chk("dc gain", TONE, tuning_step_word);
    chk("loop offset", 14'(p0 - 16'h2345), 14'(sine_phase));
    err_val <= 24'h000100;
    cyc(100);
    h = tuning_step_word;
    chk("track", 1'b1, h > TONE);
    cyc(100);
    chk("integrate", 1'b1, tuning_step_word > h);
    // manual then automatic holdover
    ctl(32'h09);
    st(32'h09);
    h = tuning_step_word;
    cyc(100);
    chk("hold", h, tuning_step_word);
    ctl(32'h05);
    st(32'h0A);
    ref_lost <= 1'b1;
    cyc(4);
    st(32'h09);
    ref_lost <= 1'b0;
    err_val  <= 24'h000000;
    cyc(40);
    // estimator hand-over before tracking
    ctl(32'h00);
    ctl(32'h11);
    st(32'h0B);
    est_go <= 1'b1;
    cyc(1);
    est_go <= 1'b0;
    cyc(4);
    chk("estimate", EST, tuning_step_word);
    st(32'h1A);
    ctl(32'h02);
    chk("est tone", EST, tuning_step_word);
    // reset in mid-run clears lock history and the accumulator
    reset <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    cyc(2);
    chk("rerun step", 48'h0, tuning_step_word);
    chk("rerun phase", 48'h0, sine_phase);
    st(32'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
